// ===== dv/ascd_host.sv
`timescale 1ns/10ps
module ascd_host
(
  // clock
  input wire logic clk,
  // serial lines to the device
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // two bytes per frame; sclk idles low and stands still between frames
  task automatic send(input logic [15:0] d);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) din <= d[i];
      repeat (3) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din <= ~d[0];
  endtask : send
endmodule : ascd_host

// ===== dv/ascd_properties.sv
`timescale 1ns/10ps
module ascd_properties
  import ascd_pkg::*;
(
  // clock, reset and pins
  input wire logic clk, resetn, sclk, cs_n, din, convert_strobe_n,
  // registers
  input wire logic [7:0] conversion_request_q, configuration_byte_q,
  input wire logic [7:0] sample_averaging_control_q, unipolar_pair_select_q,
  input wire logic [7:0] bipolar_pair_select_q,
  // sequencing
  input wire logic scan_busy_q, conv_start_q, conv_diff_q, conv_bipolar_q,
  input wire logic conv_temp_q, conv_average_q, queue_clear_q,
  input wire logic [3:0] conv_channel_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic seen_temp_q;
  logic chan_go;
  logic [2:0] pidx;
  assign chan_go = conv_start_q && !conv_temp_q;
  assign pidx = 3'h7 - conv_channel_q[3:1];
  // remembers a temperature start so later channels of the scan can be judged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) seen_temp_q <= 1'b0;
    else if (!scan_busy_q) seen_temp_q <= 1'b0;
    else if (conv_start_q && conv_temp_q) seen_temp_q <= 1'b1;
  end
  reset_values_a: assert property (disable iff (1'b0) !resetn ##1 !resetn |->
    configuration_byte_q == SETUP_RESET && conversion_request_q == 8'h00 &&
    sample_averaging_control_q == 8'h00 && (unipolar_pair_select_q | bipolar_pair_select_q) == 8'h00)
    else $error("register reset value wrong");
  start_spacing_a: assert property (conv_start_q |=> !conv_start_q [*8])
    else $error("conversion starts too close");
  strobe_skip_a: assert property (chan_go && !configuration_byte_q[5] |->
    conv_channel_q != STROBE_CH && !(conv_channel_q == NEGREF_CH && conv_diff_q))
    else $error("strobe channel converted");
  negref_skip_a: assert property (chan_go && configuration_byte_q[3:2] == 2'h3 |->
    conv_channel_q != NEGREF_CH) else $error("reference channel converted");
  pair_mode_a: assert property (chan_go && !conv_channel_q[0] |->
    conv_diff_q == (unipolar_pair_select_q[pidx] | bipolar_pair_select_q[pidx]) &&
    conv_bipolar_q == (bipolar_pair_select_q[pidx] && !unipolar_pair_select_q[pidx]))
    else $error("pair mode wrong");
  avg_follow_a: assert property (chan_go && configuration_byte_q[5:4] != 2'h3 |->
    conv_average_q == sample_averaging_control_q[AVG_ON_BIT]) else $error("averaging wrong");
  ext_no_avg_a: assert property (conv_start_q && configuration_byte_q[5:4] == 2'h3 |->
    !conv_average_q) else $error("averaging in external mode");
  temp_first_a: assert property (chan_go && conversion_request_q[CONV_TEMP] |->
    seen_temp_q) else $error("temperature not first");
  temp_once_a: assert property (conv_start_q && conv_temp_q |->
    conversion_request_q[CONV_TEMP] && !seen_temp_q) else $error("extra temperature");
  write_start_a: assert property ($changed(conversion_request_q) &&
    conversion_request_q[7] && configuration_byte_q[5] && !$past(scan_busy_q) |-> scan_busy_q)
    else $error("conversion write did not start scan");
  uni_write_a: assert property (!$stable(unipolar_pair_select_q) &&
    |unipolar_pair_select_q |-> configuration_byte_q[1:0] == 2'h2)
    else $error("unipolar register written wrongly");
  bip_write_a: assert property (!$stable(bipolar_pair_select_q) &&
    |bipolar_pair_select_q |-> configuration_byte_q[1:0] == 2'h3)
    else $error("bipolar register written wrongly");
  cover property (conv_start_q && conv_temp_q);
  cover property (conv_start_q && conv_diff_q);
  cover property ($rose(queue_clear_q));
endmodule : ascd_properties
bind ascd_top ascd_properties u_ascd_properties (.*);

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ascd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic strobe_n = 1'b1;
  logic sclk, cs_n, din, busy, start, diff, bip, temp, avg, clr, first_temp;
  logic [7:0] conv_q, cfg_q, avg_q, uni_q, bip_q;
  logic [3:0] chan, last_ch;
  int failures = 0;
  int n_tests = 0;
  int n_st = 0;
  int n_clr = 0;
  int busy_cyc = 0;
  always #4 clk = ~clk;
  ascd_host u_ascd_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din));
  ascd_top u_ascd_top (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .convert_strobe_n(strobe_n), .conversion_request_q(conv_q), .configuration_byte_q(cfg_q),
    .sample_averaging_control_q(avg_q), .unipolar_pair_select_q(uni_q),
    .bipolar_pair_select_q(bip_q), .scan_busy_q(busy), .conv_start_q(start),
    .conv_channel_q(chan), .conv_diff_q(diff), .conv_bipolar_q(bip), .conv_temp_q(temp),
    .conv_average_q(avg), .queue_clear_q(clr));
  always @(posedge clk) begin
    if (start === 1'b1) begin
      if (n_st == 0) first_temp <= temp;
      last_ch <= chan;
      n_st <= n_st + 1;
    end
    if (clr === 1'b1) n_clr <= n_clr + 1;
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // counts conversion starts until the scan finishes
  task automatic scan_wait(input string what, input int exp_n);
    int k;
    k = 0;
    repeat (8) @(posedge clk);
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    check(what, exp_n, n_st);
    $display("test %s done", what);
  endtask : scan_wait
  task automatic t_reset();
    check("reset cfg conv", {cfg_q, conv_q}, 16'h2000);
    check("reset pairs", {uni_q, bip_q}, 16'h0000);
    check("reset avg", avg_q, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_pairs();
    u_ascd_host.send(16'h6680);
    check("unipolar", 16'h0080, uni_q);
    u_ascd_host.send(16'h6780);
    check("bipolar", 16'h8080, {uni_q, bip_q});
    $display("test pairs done");
  endtask : t_pairs
  task automatic t_fresh();
    n_st = 0;
    u_ascd_host.send(16'h649e);
    check("fresh byte", 16'h649e, {cfg_q, conv_q});
    scan_wait("single", 1);
    check("channel", 16'h0003, last_ch);
  endtask : t_fresh
  task automatic t_range();
    n_st = 0;
    u_ascd_host.send(16'ha100);
    scan_wait("range up", 5);
    check("temp first", 16'h0001, first_temp);
  endtask : t_range
  task automatic t_strobe();
    u_ascd_host.send(16'h4c00);
    n_st = 0;
    u_ascd_host.send(16'he200);
    repeat (40) @(posedge clk);
    check("no write start", 16'h0000, n_st);
    @(posedge clk) strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    strobe_n <= 1'b1;
    scan_wait("strobe range", 2);
  endtask : t_strobe
  task automatic t_repeat();
    u_ascd_host.send(16'h3300);
    u_ascd_host.send(16'h6400);
    n_st = 0;
    busy_cyc = 0;
    u_ascd_host.send(16'hac00);
    scan_wait("repeat", 4);
    check("scan time", 1, busy_cyc >= 4 * 4 * SAMPLE_CYC && busy_cyc <= 4 * 4 * SAMPLE_CYC + 20);
  endtask : t_repeat
  task automatic t_ext();
    u_ascd_host.send(16'h7400);
    n_st = 0;
    u_ascd_host.send(16'h9600);
    u_ascd_host.send(16'h0000);
    scan_wait("external", 1);
  endtask : t_ext
  task automatic t_clear();
    n_clr = 0;
    u_ascd_host.send(16'h1800);
    repeat (4) @(posedge clk);
    check("queue clear", 16'h7401, {cfg_q, 8'(n_clr)});
    u_ascd_host.send(16'h1000);
    repeat (4) @(posedge clk);
    check("full reset", 16'h2000, {cfg_q, conv_q | avg_q | uni_q | bip_q});
    check("clear pulses", 16'h0002, n_clr);
    $display("test clear done");
  endtask : t_clear
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_pairs();
    t_fresh();
    t_range();
    t_strobe();
    t_repeat();
    t_ext();
    t_clear();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    $display("[ERR] watchdog expected done seen timeout");
    summarize();
  end
endmodule : tb_top

// ===== src/ascd_pkg.sv
// Behaviour
// - byte with bit 7 set loads conversion request: channel 6:3, scan 2:1, temp 0
// - channel field is binary 0..15; pairs addressed by their lower channel
// - scan 00 is 0..N, 01 is N..15, 10 repeats N, 11 converts N once
// - range scans give one result per single channel or pair, plus temperature
// - repeat scan result count comes from the averaging repeat count field
// - temperature request gives one temperature result, placed first in the scan
// - channels acting as convert strobe or negative reference are skipped
// - top pair is ignored when either member is reassigned
// - modes 10/11 start on conversion write; modes 00/01 on strobe low pulse
// - setup bits 5:4 clock mode, 3:2 reference, 1:0 pair register select
// - select 10 sends next byte to unipolar pairs, 11 to bipolar pairs
// - select 00 or 01 writes no pair register; next byte is a fresh command
// - pair enabled in both registers is treated as unipolar
// - unipolar results straight binary, bipolar results two's complement
// - averaging register sets up to 32 samples per result and repeat count
// - averaging happens only while the averaging-on bit is 1
// - externally clocked mode 11 never averages
// - reset byte with bit 3 at 1 clears result queue; with 0 resets all registers
// - internally timed scan time: sample time x samples x results plus extras
// - mode 11 conversion time follows serial clock and select-high gaps; here a fixed SAMPLE_CYC per result as in the internal modes
// - byte 01xxxxxx is a setup write
// - registers reset to zero except setup, which starts in clock mode 10
// - input sampled on rising serial clock while select low, msb first
// - each result is two bytes: four zero bits then twelve-bit value
package ascd_pkg;
  localparam logic [7:0] SETUP_RESET = 8'h20;
  localparam int CONV_CH_HI = 6;
  localparam int CONV_CH_LO = 3;
  localparam int CONV_SCAN_HI = 2;
  localparam int CONV_TEMP = 0;
  localparam int SETUP_CK_HI = 5;
  localparam int SETUP_REF_HI = 3;
  localparam int AVG_ON_BIT = 4;
  localparam int AVG_CNT_HI = 3;
  localparam int RST_BIT = 3;
  localparam int NUM_CH = 16;
  localparam logic [3:0] STROBE_CH = 4'hf;
  localparam logic [3:0] NEGREF_CH = 4'he;
  // per-sample, temperature and reference wake times in ns
  localparam int T_SAMPLE_NS = 3000;
  localparam int T_TEMP_NS = 6000;
  localparam int T_WAKE_NS = 65000;
  localparam int CLK_NS = 8;
  localparam int SAMPLE_CYC = T_SAMPLE_NS / CLK_NS;
  localparam int TEMP_CYC = T_TEMP_NS / CLK_NS;
  localparam int WAKE_CYC = T_WAKE_NS / CLK_NS;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {SCAN_UP_TO, SCAN_FROM, SCAN_REPEAT, SCAN_ONCE} ascd_scan_t;
endpackage : ascd_pkg

// ===== src/ascd_shift_if.sv
`timescale 1ns/10ps
interface ascd_shift_if;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_first;
  modport rx (output byte_valid, output byte_data, output byte_first);
  modport core (input byte_valid, input byte_data, input byte_first);
endinterface : ascd_shift_if

// ===== src/ascd_shift_rx.sv
`timescale 1ns/10ps
module ascd_shift_rx
  import ascd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised serial lines
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic din_s,
  // bytes out
  ascd_shift_if.rx bus
);
  logic sclk_prev_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic first_pend_q;
  wire rise = sclk_s & ~sclk_prev_q & ~cs_n_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sclk_prev_q <= 1'b0;
    else sclk_prev_q <= sclk_s;
  end

  // msb first, taken on rising serial clock while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      bus.byte_valid <= 1'b0;
      bus.byte_data <= 8'h00;
    end else begin
      bus.byte_valid <= 1'b0;
      if (cs_n_s) begin
        bit_cnt_q <= 3'h0;
      end else if (rise) begin
        shift_q <= {shift_q[5:0], din_s};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          bus.byte_valid <= 1'b1;
          bus.byte_data <= {shift_q, din_s};
        end
      end
    end
  end

  // first byte of a frame is always a command byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_pend_q <= 1'b1;
      bus.byte_first <= 1'b0;
    end else begin
      if (cs_n_s) first_pend_q <= 1'b1;
      else if (bus.byte_valid) first_pend_q <= 1'b0;
      if (rise && bit_cnt_q == 3'h7) bus.byte_first <= first_pend_q;
    end
  end
endmodule : ascd_shift_rx

// ===== src/ascd_top.sv
`timescale 1ns/10ps
module ascd_top
  import ascd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial port and convert strobe from host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic convert_strobe_n,
  // register contents
  output logic [7:0] conversion_request_q,
  output logic [7:0] configuration_byte_q,
  output logic [7:0] sample_averaging_control_q,
  output logic [7:0] unipolar_pair_select_q,
  output logic [7:0] bipolar_pair_select_q,
  // conversion sequencing
  output logic scan_busy_q,
  output logic conv_start_q,
  output logic [3:0] conv_channel_q,
  output logic conv_diff_q,
  output logic conv_bipolar_q,
  output logic conv_temp_q,
  output logic conv_average_q,
  output logic queue_clear_q
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [SYNC_STAGES-1:0] sclk_sync_q, cs_sync_q, din_sync_q, cnv_sync_q;
  logic cnv_prev_q;
  logic pair_next_q;
  logic pair_bip_q;
  logic [3:0] cur_q, last_q;
  logic [2:0] repeat_left_q;
  logic temp_pend_q;
  logic fin_q;
  logic [15:0] wait_q;
  logic start_req;
  logic [15:0] ch_ok;
  logic [1:0] ck_mode;
  ascd_scan_t scan_mode;

  ascd_shift_if sif ();

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // two-stage synchronisers; only the last stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_q <= '0;
      cs_sync_q <= '1;
      din_sync_q <= '0;
      cnv_sync_q <= '1;
      cnv_prev_q <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], sclk};
      cs_sync_q <= {cs_sync_q[0], cs_n};
      din_sync_q <= {din_sync_q[0], din};
      cnv_sync_q <= {cnv_sync_q[0], convert_strobe_n};
      cnv_prev_q <= cnv_sync_q[1];
    end
  end

  ascd_shift_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_s(sclk_sync_q[1]),
    .cs_n_s(cs_sync_q[1]),
    .din_s(din_sync_q[1]),
    .bus(sif.rx)
  );

  wire [7:0] b = sif.byte_data;
  wire cmd_byte = sif.byte_valid & ~(pair_next_q & ~sif.byte_first);
  wire wr_conv = cmd_byte & b[7];
  wire wr_setup = cmd_byte & (b[7:6] == 2'b01);
  wire wr_avg = cmd_byte & (b[7:5] == 3'b001);
  wire wr_rst = cmd_byte & (b[7:4] == 4'b0001);
  wire full_reset = wr_rst & ~b[RST_BIT];

  assign ck_mode = configuration_byte_q[SETUP_CK_HI -: 2];
  assign scan_mode = ascd_scan_t'(conversion_request_q[CONV_SCAN_HI -: 2]);

  // register file; full reset returns power-up values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_request_q <= 8'h00;
      configuration_byte_q <= SETUP_RESET;
      sample_averaging_control_q <= 8'h00;
      unipolar_pair_select_q <= 8'h00;
      bipolar_pair_select_q <= 8'h00;
      pair_next_q <= 1'b0;
      pair_bip_q <= 1'b0;
    end else if (full_reset) begin
      conversion_request_q <= 8'h00;
      configuration_byte_q <= SETUP_RESET;
      sample_averaging_control_q <= 8'h00;
      unipolar_pair_select_q <= 8'h00;
      bipolar_pair_select_q <= 8'h00;
      pair_next_q <= 1'b0;
    end else if (sif.byte_valid) begin
      pair_next_q <= 1'b0;
      if (pair_next_q && !sif.byte_first) begin
        if (pair_bip_q) bipolar_pair_select_q <= b;
        else unipolar_pair_select_q <= b;
      end else if (wr_conv) begin
        conversion_request_q <= b;
      end else if (wr_setup) begin
        configuration_byte_q <= b;
        pair_next_q <= b[1];
        pair_bip_q <= b[0];
      end else if (wr_avg) begin
        sample_averaging_control_q <= b;
      end
    end
  end

  // queue clear pulse, also on full reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) queue_clear_q <= 1'b0;
    else queue_clear_q <= wr_rst;
  end

  // pair enable: bit 7 covers 0/1 down to bit 0 for 14/15
  function automatic logic pair_en(input logic [7:0] r, input logic [3:0] ch);
    pair_en = r[3'h7 - ch[3:1]];
  endfunction : pair_en

  // channels usable for conversion
  always_comb begin
    ch_ok = '1;
    if (!ck_mode[1]) ch_ok[STROBE_CH] = 1'b0;
    if (configuration_byte_q[SETUP_REF_HI -: 2] == 2'b11) ch_ok[NEGREF_CH] = 1'b0;
    if ((pair_en(unipolar_pair_select_q, NEGREF_CH) || pair_en(bipolar_pair_select_q, NEGREF_CH))
        && !(ch_ok[STROBE_CH] && ch_ok[NEGREF_CH])) begin
      ch_ok[NEGREF_CH] = 1'b0;
      ch_ok[STROBE_CH] = 1'b0;
    end
  end

  wire strobe_fall = cnv_prev_q & ~cnv_sync_q[1];
  assign start_req = !scan_busy_q &&
                     ((ck_mode[1] && wr_conv) || (!ck_mode[1] && strobe_fall));

  wire is_pair = pair_en(unipolar_pair_select_q, cur_q) | pair_en(bipolar_pair_select_q, cur_q);
  wire [3:0] step = is_pair ? 4'h2 : 4'h1;
  wire avg_on = sample_averaging_control_q[AVG_ON_BIT] & (ck_mode != 2'b11);
  wire [2:0] navg_sel = {1'b0, sample_averaging_control_q[AVG_CNT_HI -: 2]};
  // samples per result: 4, 8, 16 or 32 when averaging
  wire [15:0] samples = avg_on ? (16'h4 << navg_sel) : 16'h1;
  wire [15:0] wake = (configuration_byte_q[SETUP_REF_HI -: 2] == 2'b00) ? 16'(WAKE_CYC) : 16'h0;

  // scan sequencer: temperature first, then channels in order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_busy_q <= 1'b0;
      conv_start_q <= 1'b0;
      conv_channel_q <= 4'h0;
      conv_diff_q <= 1'b0;
      conv_bipolar_q <= 1'b0;
      conv_temp_q <= 1'b0;
      conv_average_q <= 1'b0;
      cur_q <= 4'h0;
      last_q <= 4'h0;
      repeat_left_q <= 3'h0;
      temp_pend_q <= 1'b0;
      wait_q <= 16'h0;
      fin_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      if (full_reset) begin
        scan_busy_q <= 1'b0;
        fin_q <= 1'b0;
      end else if (start_req) begin
        scan_busy_q <= 1'b1;
        fin_q <= 1'b0;
        temp_pend_q <= conversion_request_q[CONV_TEMP] | (wr_conv & b[CONV_TEMP]);
        wait_q <= wake;
        case (wr_conv ? ascd_scan_t'(b[CONV_SCAN_HI -: 2]) : scan_mode)
          SCAN_UP_TO: begin
            cur_q <= 4'h0;
            last_q <= wr_conv ? b[CONV_CH_HI -: 4] : conversion_request_q[CONV_CH_HI -: 4];
          end
          SCAN_FROM: begin
            cur_q <= wr_conv ? b[CONV_CH_HI -: 4] : conversion_request_q[CONV_CH_HI -: 4];
            last_q <= 4'(NUM_CH - 1);
          end
          default: begin
            cur_q <= wr_conv ? b[CONV_CH_HI -: 4] : conversion_request_q[CONV_CH_HI -: 4];
            last_q <= wr_conv ? b[CONV_CH_HI -: 4] : conversion_request_q[CONV_CH_HI -: 4];
          end
        endcase
        // repeat count 1,2,3,4 results
        repeat_left_q <= {1'b0, sample_averaging_control_q[1:0]};
      end else if (scan_busy_q) begin
        if (wait_q != 16'h0) begin
          wait_q <= wait_q - 16'h1;
        end else if (fin_q) begin
          // busy covers the last conversion too, so scan time matches the sum
          fin_q <= 1'b0;
          scan_busy_q <= 1'b0;
        end else if (temp_pend_q) begin
          temp_pend_q <= 1'b0;
          conv_start_q <= 1'b1;
          conv_temp_q <= 1'b1;
          conv_average_q <= 1'b0;
          wait_q <= 16'(TEMP_CYC);
        end else begin
          conv_temp_q <= 1'b0;
          if (ch_ok[cur_q]) begin
            conv_start_q <= 1'b1;
            conv_channel_q <= {cur_q[3:1], cur_q[0] & ~is_pair};
            conv_diff_q <= is_pair;
            // unipolar wins when both set
            conv_bipolar_q <= ~pair_en(unipolar_pair_select_q, cur_q)
                              & pair_en(bipolar_pair_select_q, cur_q);
            conv_average_q <= avg_on;
            wait_q <= 16'(SAMPLE_CYC * samples);
          end
          if (scan_mode == SCAN_REPEAT && repeat_left_q != 3'h0) begin
            // one extra result per count step
            repeat_left_q <= repeat_left_q - 3'h1;
          end else if (cur_q >= last_q || {1'b0, cur_q} + {1'b0, step} > 5'(NUM_CH - 1)
                       && scan_mode != SCAN_REPEAT) begin
            fin_q <= 1'b1;
          end else if (scan_mode == SCAN_UP_TO || scan_mode == SCAN_FROM) begin
            cur_q <= cur_q + step;
          end else begin
            fin_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule : ascd_top
